/* File: logic/amc_code_sat.sv */
`timescale 1ns/1ns
`default_nettype none
`include "amc_regs.svh"
module amc_code_sat #(
   parameter int IN_W = 20
) (
   input  wire logic signed [IN_W-1:0]        raw,
   output logic             [`AMC_CODE_W-1:0] code
);
   localparam logic signed [IN_W-1:0] POS_LIM = IN_W'(32767);
   localparam logic signed [IN_W-1:0] NEG_LIM = -IN_W'(32768);

   wire over_pos = (raw >= POS_LIM);
   wire over_neg = (raw <= NEG_LIM);

   // Clamp at full scale, else keep low bits
   assign code = over_pos ? `AMC_CODE_POS_FS :
                 over_neg ? `AMC_CODE_NEG_FS :
                 raw[`AMC_CODE_W-1:0]; // see R16, see R13
endmodule
`default_nettype wire

/* File: logic/amc_mode_ctrl.sv */
// The AHB-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "amc_regs.svh"
module amc_mode_ctrl #(
   parameter int RAW_W         = 20,
   parameter int SETTLE_CYCLES = `AMC_SPAN_SETTLE_US * `AMC_CLK_MHZ,
   parameter int RECOV_CYCLES  = `AMC_RECOVERY_US * `AMC_CLK_MHZ,
   parameter int CONV_CYCLES   = (`AMC_CONV_NS * `AMC_CLK_MHZ) / 1000
) (
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic                          hreadyout,
   output logic                          hresp,
   output logic [31:0]                   hrdata,
   input  wire logic                     reference_source_select,
   input  wire logic                     input_span_select,
   input  wire logic                     power_down_request_n,
   input  wire logic                     readout_interface_select,
   input  wire logic                     byte_mode_select,
   input  wire logic                     sample_trigger_a,
   input  wire logic                     sample_trigger_b,
   input  wire logic signed [RAW_W-1:0]  raw_sample,
   output amc_pkg::amc_cfg_t             cfg,
   output amc_pkg::amc_pwr_t             power_state,
   output amc_pkg::amc_readout_t         readout_mode,
   output logic                          hold_a,
   output logic                          hold_b,
   output logic                          busy,
   output logic                          settling,
   output logic [`AMC_CODE_W-1:0]        result_code,
   output logic                          result_valid
);
   import amc_pkg::*;

   // Pin synchronisers
   amc_pins_t pins_raw;
   amc_pins_t pins;

   assign pins_raw = '{
      ref_sel:     reference_source_select,
      span_wide:   input_span_select,
      pd_n:        power_down_request_n,
      readout_sel: readout_interface_select,
      byte_sel:    byte_mode_select,
      trig_a:      sample_trigger_a,
      trig_b:      sample_trigger_b
   };

   amc_sync2 #(
      .W ($bits(amc_pins_t))
   ) u_pin_sync (
      .clk   (hclk),
      .rst_n (hresetn),
      .d     (pins_raw),
      .q     (pins)
   );

   // AHB-Lite slave
   logic                     wr_pend_reg;
   logic                     rd_pend_reg;
   logic [7:0]               addr_reg;
   logic [2:0]               ctrl_reg;
   logic [2:0]               ctrl_next;
   logic [RAW_W-1:0]         test_raw_reg;
   logic [31:0]              rdata_next;
   logic [31:0]              conv_count_reg;

   wire        addr_phase  = hsel && hready && htrans[1];
   wire        wr_ctrl     = wr_pend_reg && (addr_reg == `AMC_CTRL_OFS);
   wire        wr_test_raw = wr_pend_reg && (addr_reg == `AMC_TEST_RAW_OFS);
   wire        trig_en     = ctrl_reg[`AMC_CTRL_TRIG_EN];
   wire        soft_trig   = ctrl_reg[`AMC_CTRL_SOFT_TRIG];
   wire        test_mode   = ctrl_reg[`AMC_CTRL_TEST_MODE];

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
      end else begin
         wr_pend_reg <= addr_phase && hwrite;
         rd_pend_reg <= addr_phase && !hwrite;
         addr_reg    <= haddr[7:0];
      end
   end

   // Soft trigger clears itself after one cycle
   always_comb begin
      ctrl_next = ctrl_reg;
      ctrl_next[`AMC_CTRL_SOFT_TRIG] = 1'b0;
      if (wr_ctrl) begin
         ctrl_next = hwdata[2:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg     <= `AMC_CTRL_RESET;
         test_raw_reg <= '0;
      end else begin
         ctrl_reg <= ctrl_next;
         if (wr_test_raw) begin
            test_raw_reg <= hwdata[RAW_W-1:0];
         end
      end
   end

   // Power state decode
   amc_pwr_t pwr_next;

   assign pwr_next = pins.pd_n      ? AMC_PWR_NORMAL  :
                     pins.span_wide ? AMC_PWR_STANDBY :
                                      AMC_PWR_SHUTDOWN; // see R8

   // Readout decode
   amc_readout_t rd_next;

   assign rd_next = !pins.readout_sel ? AMC_RD_PARALLEL :  // see R11
                    pins.byte_sel     ? AMC_RD_BYTE     :
                                        AMC_RD_SERIAL;     // see R12

   // Analog configuration decode
   amc_cfg_t cfg_next;
   wire      powered = (pwr_next != AMC_PWR_SHUTDOWN);

   assign cfg_next = '{
      bandgap_en:       pins.ref_sel && powered,        // see R1, see R2, see R9
      ref_pin_drive_en: pins.ref_sel && powered,        // see R1, see R2
      ref_buffer_en:    powered,                        // see R3
      regulators_en:    powered,                        // see R9
      front_end_en:     (pwr_next == AMC_PWR_NORMAL),   // see R10
      span_wide:        pins.span_wide                  // see R5, see R6
   };

   // Follows pin levels every cycle, so reset release picks up the strap
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg          <= '0;
         power_state  <= AMC_PWR_SHUTDOWN;
         readout_mode <= AMC_RD_PARALLEL;
      end else begin
         cfg          <= cfg_next;      // see R4, see R7
         power_state  <= pwr_next;
         readout_mode <= rd_next;
      end
   end

   // Settling after span change or power-down release
   logic        span_prev_reg;
   logic        pd_n_prev_reg;
   logic        seen_reg;
   logic [15:0] settle_cnt_reg;
   logic [15:0] settle_cnt_next;

   wire span_change = seen_reg && (pins.span_wide != span_prev_reg);
   wire pd_release  = seen_reg && pins.pd_n && !pd_n_prev_reg;

   always_comb begin
      settle_cnt_next = settle_cnt_reg;
      if (settle_cnt_reg != 16'h0000) begin
         settle_cnt_next = settle_cnt_reg - 16'h0001;
      end
      if (span_change && (settle_cnt_next < 16'(SETTLE_CYCLES))) begin
         settle_cnt_next = 16'(SETTLE_CYCLES);       // see R7
      end
      // Longer of the two waits wins
      if (pd_release && (settle_cnt_next < 16'(RECOV_CYCLES))) begin
         settle_cnt_next = 16'(RECOV_CYCLES);        // see R10
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         span_prev_reg  <= 1'b0;
         pd_n_prev_reg  <= 1'b0;
         seen_reg       <= 1'b0;
         settle_cnt_reg <= 16'h0000;
      end else begin
         span_prev_reg  <= pins.span_wide;
         pd_n_prev_reg  <= pins.pd_n;
         seen_reg       <= 1'b1;
         settle_cnt_reg <= settle_cnt_next;
      end
   end

   assign settling = (settle_cnt_reg != 16'h0000);

   // Trigger edges
   logic trig_a_prev_reg;
   logic trig_b_prev_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trig_a_prev_reg <= 1'b1;
         trig_b_prev_reg <= 1'b1;
      end else begin
         trig_a_prev_reg <= pins.trig_a;
         trig_b_prev_reg <= pins.trig_b;
      end
   end

   wire can_sample = trig_en && (pwr_next == AMC_PWR_NORMAL);
   wire rise_a     = (pins.trig_a && !trig_a_prev_reg) || soft_trig;
   wire rise_b     = (pins.trig_b && !trig_b_prev_reg) || soft_trig;

   // Conversion sequencer
   amc_conv_t   cv_reg;
   amc_conv_t   cv_next;
   logic [15:0] cv_cnt_reg;
   logic        hold_a_next;
   logic        hold_b_next;

   wire cv_done = (cv_reg == AMC_CV_CONV) && (cv_cnt_reg == 16'h0001);

   always_comb begin
      cv_next     = cv_reg;
      hold_a_next = hold_a;
      hold_b_next = hold_b;
      case (cv_reg)
         AMC_CV_IDLE, AMC_CV_HOLD: begin
            if (!can_sample) begin
               cv_next     = AMC_CV_IDLE;
               hold_a_next = 1'b0;
               hold_b_next = 1'b0;
            end else begin
               hold_a_next = hold_a || rise_a;   // see R15
               hold_b_next = hold_b || rise_b;   // see R15
               cv_next     = (hold_a_next && hold_b_next) ? AMC_CV_CONV :
                             (hold_a_next || hold_b_next) ? AMC_CV_HOLD : AMC_CV_IDLE;
            end
         end
         AMC_CV_CONV: begin
            if (cv_done) begin
               cv_next     = AMC_CV_IDLE;
               hold_a_next = 1'b0;
               hold_b_next = 1'b0;
            end
         end
         default: begin
            cv_next     = AMC_CV_IDLE;
            hold_a_next = 1'b0;
            hold_b_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cv_reg     <= AMC_CV_IDLE;
         hold_a     <= 1'b0;
         hold_b     <= 1'b0;
         cv_cnt_reg <= 16'h0000;
      end else begin
         cv_reg <= cv_next;
         hold_a <= hold_a_next;
         hold_b <= hold_b_next;
         if (cv_reg != AMC_CV_CONV && cv_next == AMC_CV_CONV) begin
            cv_cnt_reg <= 16'(CONV_CYCLES);
         end else if (cv_cnt_reg != 16'h0000) begin
            cv_cnt_reg <= cv_cnt_reg - 16'h0001;
         end
      end
   end

   assign busy = (cv_reg == AMC_CV_CONV);

   // Output code
   logic [`AMC_CODE_W-1:0] sat_code;
   wire  [RAW_W-1:0]       sat_in = test_mode ? test_raw_reg : raw_sample;

   amc_code_sat #(
      .IN_W (RAW_W)
   ) u_code_sat (
      .raw  (sat_in),
      .code (sat_code)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result_code    <= `AMC_CODE_ZERO;
         result_valid   <= 1'b0;
         conv_count_reg <= 32'h0000_0000;
      end else begin
         result_valid <= cv_done;
         if (cv_done) begin
            result_code    <= sat_code;                       // see R13
            conv_count_reg <= conv_count_reg + 32'h0000_0001;
         end
      end
   end

   // Register read mux
   wire [31:0] status_word = {
      18'h0_0000,
      2'(readout_mode),
      2'(power_state),
      2'(cv_reg),
      settling,
      busy,
      cfg.front_end_en,
      cfg.regulators_en,
      cfg.ref_buffer_en,
      cfg.ref_pin_drive_en,
      cfg.bandgap_en,
      cfg.span_wide
   };
   wire [31:0] lsb_word = cfg.span_wide ? `AMC_LSB_WIDE_10NV :
                                          `AMC_LSB_NARROW_10NV; // see R14

   always_comb begin
      case (haddr[7:0])
         `AMC_CTRL_OFS:       rdata_next = {29'h0000_0000, ctrl_reg};
         `AMC_STATUS_OFS:     rdata_next = status_word;
         `AMC_RESULT_OFS:     rdata_next = {16'h0000, result_code};
         `AMC_LSB_OFS:        rdata_next = lsb_word;
         `AMC_CONV_COUNT_OFS: rdata_next = conv_count_reg;
         `AMC_TEST_RAW_OFS:   rdata_next = {{(32-RAW_W){1'b0}}, test_raw_reg};
         default:             rdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata <= (haddr[31:8] == 24'h00_0000) ? rdata_next : 32'h0000_0000;
      end
   end

endmodule
`default_nettype wire

/* File: logic/amc_sync2.sv */
`timescale 1ns/1ns
`default_nettype none
module amc_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule
`default_nettype wire

/* File: shared/amc_pkg.sv */
package amc_pkg;

   typedef enum logic [1:0] {
      AMC_PWR_NORMAL   = 2'b00,
      AMC_PWR_STANDBY  = 2'b01,
      AMC_PWR_SHUTDOWN = 2'b10
   } amc_pwr_t;

   typedef enum logic [1:0] {
      AMC_RD_PARALLEL = 2'b00,
      AMC_RD_SERIAL   = 2'b01,
      AMC_RD_BYTE     = 2'b10
   } amc_readout_t;

   typedef enum logic [1:0] {
      AMC_CV_IDLE = 2'b00,
      AMC_CV_HOLD = 2'b01,
      AMC_CV_CONV = 2'b10
   } amc_conv_t;

   typedef struct packed {
      logic ref_sel;
      logic span_wide;
      logic pd_n;
      logic readout_sel;
      logic byte_sel;
      logic trig_a;
      logic trig_b;
   } amc_pins_t;

   typedef struct packed {
      logic bandgap_en;
      logic ref_pin_drive_en;
      logic ref_buffer_en;
      logic regulators_en;
      logic front_end_en;
      logic span_wide;
   } amc_cfg_t;

endpackage

/* File: shared/amc_regs.svh */
// Function
// R1 - Reference select high: band-gap on, drives pin
// R2 - Reference select low: band-gap off, pin input
// R3 - Reference buffer stays enabled while operating
// R4 - Reference select asynchronous; power-up follows level
// R5 - Span select high: all channels ten volt
// R6 - Span select low: all channels five volt
// R7 - Span change immediate; host waits extra settling
// R8 - Power-down low: standby or shutdown by span
// R9 - Shutdown powers all off; standby keeps reference
// R10 - Power-down anytime; host waits recovery after release
// R11 - Readout select low: parallel word readout
// R12 - Readout high: serial or byte by byte select
// R13 - Sixteen-bit twos complement, same every channel, span
// R14 - Code step is full scale over 65536
// R15 - Trigger rising edge holds and starts conversion
// R16 - Saturate to 7FFF and 8000, zero gives 0000
`ifndef AMC_REGS_SVH
`define AMC_REGS_SVH

// Register byte offsets
`define AMC_CTRL_OFS        8'h00
`define AMC_STATUS_OFS      8'h04
`define AMC_RESULT_OFS      8'h08
`define AMC_LSB_OFS         8'h0C
`define AMC_CONV_COUNT_OFS  8'h10
`define AMC_TEST_RAW_OFS    8'h14

// Control fields
`define AMC_CTRL_TRIG_EN    0
`define AMC_CTRL_SOFT_TRIG  1
`define AMC_CTRL_TEST_MODE  2
`define AMC_CTRL_RESET      3'h1

// Code format
`define AMC_CODE_W          16
`define AMC_CODE_STEPS      65536
`define AMC_CODE_POS_FS     16'h7FFF
`define AMC_CODE_NEG_FS     16'h8000
`define AMC_CODE_ZERO       16'h0000

// Step weight in units of 10 nV
`define AMC_LSB_WIDE_10NV   32'h0000_7736
`define AMC_LSB_NARROW_10NV 32'h0000_3B9B

// Timing
`define AMC_CLK_MHZ         250
`define AMC_SPAN_SETTLE_US  80
`define AMC_RECOVERY_US     100
`define AMC_CONV_NS         4000

`endif

/* File: tb/amc_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module amc_assertions #(
   parameter int RAW_W       = 20,
   parameter int CONV_CYCLES = 10
) (
   input wire logic                    hclk,
   input wire logic                    hresetn,
   input wire logic                    reference_source_select,
   input wire logic                    input_span_select,
   input wire logic                    power_down_request_n,
   input wire logic                    readout_interface_select,
   input wire logic                    byte_mode_select,
   input wire logic signed [RAW_W-1:0] raw_sample,
   input wire amc_pkg::amc_cfg_t       cfg,
   input wire amc_pkg::amc_pwr_t       power_state,
   input wire amc_pkg::amc_readout_t   readout_mode,
   input wire logic                    hold_a,
   input wire logic                    hold_b,
   input wire logic                    busy,
   input wire logic                    settling,
   input wire logic [15:0]             result_code,
   input wire logic                    result_valid
);
   import amc_pkg::*;
   logic [2:0]  up_cnt;
   logic [15:0] busy_cnt;
   wire         up = (up_cnt == 3'h7);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         up_cnt   <= 3'h0;
         busy_cnt <= 16'h0000;
      end else begin
         up_cnt   <= up ? up_cnt : up_cnt + 3'h1;
         busy_cnt <= busy ? busy_cnt + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_done;
      result_valid && !busy && !hold_a && !hold_b;
   endsequence
   chk_bandgap_follow: assert property (
      up |-> cfg.bandgap_en == ($past(reference_source_select, 3)
                                && power_state != AMC_PWR_SHUTDOWN))
      else $error("band-gap enable wrong");
   chk_ref_drive: assert property (
      up |-> cfg.ref_pin_drive_en == cfg.bandgap_en)
      else $error("reference pin drive wrong");
   chk_buffer_on: assert property (
      up && power_state == AMC_PWR_NORMAL |-> cfg.ref_buffer_en)
      else $error("reference buffer off");
   chk_span_follow: assert property (
      up |-> cfg.span_wide == $past(input_span_select, 3))
      else $error("span output wrong");
   chk_power_decode: assert property (
      up |-> power_state == ($past(power_down_request_n, 3) ? AMC_PWR_NORMAL :
             $past(input_span_select, 3) ? AMC_PWR_STANDBY : AMC_PWR_SHUTDOWN))
      else $error("power state wrong");
   chk_shutdown_off: assert property (
      power_state == AMC_PWR_SHUTDOWN |-> cfg[5:1] == 5'h00)
      else $error("circuit on in shutdown");
   chk_readout_decode: assert property (
      up |-> readout_mode == (!$past(readout_interface_select, 3) ? AMC_RD_PARALLEL :
             $past(byte_mode_select, 3) ? AMC_RD_BYTE : AMC_RD_SERIAL))
      else $error("readout mode wrong");
   chk_settle_span: assert property (
      up && $changed(cfg.span_wide) |-> ##[0:2] settling)
      else $error("no settling after span change");
   chk_settle_recov: assert property (
      up && $rose(power_state == AMC_PWR_NORMAL) |-> ##[0:2] settling)
      else $error("no recovery wait");
   chk_start_holds: assert property (
      $rose(busy) |-> hold_a && hold_b)
      else $error("busy without holds");
   chk_conv_len: assert property (
      result_valid |-> (busy_cnt == 16'(CONV_CYCLES)) ##0 s_done)
      else $error("conversion length wrong");
   chk_code_sat: assert property (
      result_valid |-> result_code == (raw_sample > 20'sh07FFF ? 16'h7FFF :
                       raw_sample < 20'shF8000 ? 16'h8000 : raw_sample[15:0]))
      else $error("result code wrong");
endmodule
bind amc_mode_ctrl amc_assertions #(.RAW_W(RAW_W), .CONV_CYCLES(CONV_CYCLES)) u_amc_assertions (
   .hclk, .hresetn, .reference_source_select, .input_span_select, .power_down_request_n,
   .readout_interface_select, .byte_mode_select, .raw_sample, .cfg, .power_state,
   .readout_mode, .hold_a, .hold_b, .busy, .settling, .result_code, .result_valid);
`default_nettype wire

/* File: tb/amc_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module amc_host_model (
   input  wire logic             hclk,
   input  wire logic             busy,
   input  wire logic             settling,
   output var amc_pkg::amc_pins_t pins
);
   import amc_pkg::*;
   initial pins = 7'b1110000;
   task automatic drive(input amc_pins_t p);
      @(posedge hclk);
      pins <= p;
      repeat (4) @(posedge hclk);
   endtask
   task automatic convert();
      int n;
      n = 0;
      while (settling !== 1'b0 && n < 200) begin
         @(posedge hclk);
         n++;
      end
      @(posedge hclk);
      pins.trig_a <= 1'b1;
      pins.trig_b <= 1'b1;
      do @(posedge hclk); while (busy !== 1'b1 && ++n < 220);
      do @(posedge hclk); while (busy !== 1'b0 && ++n < 300);
      pins.trig_a <= 1'b0;
      pins.trig_b <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "amc_regs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
   $display("mismatch %0t got %0h exp %0h", $time, a, b); end end
module tb_top;
   import amc_pkg::*;
   logic               hclk    = 1'b0;
   logic               hresetn = 1'b0;
   logic               hsel    = 1'b0;
   logic               hwrite  = 1'b0;
   logic [1:0]         htrans  = 2'h0;
   logic [31:0]        haddr   = 32'h0;
   logic [31:0]        hwdata  = 32'h0;
   logic signed [19:0] raw     = 20'sh00000;
   logic [31:0]        hrdata, rd;
   logic               hreadyout, hresp, hold_a, hold_b, busy, settling, result_valid;
   logic [15:0]        result_code, last_code;
   amc_cfg_t           cfg;
   amc_pwr_t           power_state;
   amc_readout_t       readout_mode;
   amc_pins_t          pins;
   int                 err_total = 0;
   int                 checked   = 0;
   int                 n_res     = 0;
   always #2 hclk = ~hclk;
   always @(posedge hclk) begin
      if (result_valid === 1'b1) begin
         last_code <= result_code;
         n_res     <= n_res + 1;
      end
   end
   amc_mode_ctrl #(.SETTLE_CYCLES(20), .RECOV_CYCLES(30), .CONV_CYCLES(10)) u_amc_mode_ctrl (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .reference_source_select(pins.ref_sel), .input_span_select(pins.span_wide),
      .power_down_request_n(pins.pd_n), .readout_interface_select(pins.readout_sel),
      .byte_mode_select(pins.byte_sel), .sample_trigger_a(pins.trig_a),
      .sample_trigger_b(pins.trig_b), .raw_sample(raw), .cfg, .power_state, .readout_mode,
      .hold_a, .hold_b, .busy, .settling, .result_code, .result_valid);
   amc_host_model u_amc_host_model (.hclk, .busy, .settling, .pins);
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      hwrite <= w;
      haddr  <= {24'h000000, a};
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic t_ref();
      amc_pins_t p;
      for (int i = 0; i < 2; i++) begin
         p = pins;
         p.ref_sel = i[0];
         u_amc_host_model.drive(p);
         `CHK(cfg.bandgap_en, i[0])
         `CHK(cfg.ref_pin_drive_en, i[0])
         `CHK(cfg.ref_buffer_en, 1'b1)
      end
   endtask
   task automatic t_span();
      amc_pins_t p;
      for (int i = 0; i < 2; i++) begin
         p = pins;
         p.span_wide = i[0];
         u_amc_host_model.drive(p);
         `CHK(cfg.span_wide, i[0])
         `CHK(settling, 1'b1)
         ahb(1'b0, `AMC_LSB_OFS, 32'h0);
         `CHK(rd, i ? `AMC_LSB_WIDE_10NV : `AMC_LSB_NARROW_10NV)
      end
   endtask
   task automatic t_power();
      amc_pins_t p;
      p = pins;
      p.pd_n = 1'b0;
      u_amc_host_model.drive(p);
      `CHK(power_state, AMC_PWR_STANDBY)
      `CHK({cfg.regulators_en, cfg.ref_buffer_en, cfg.bandgap_en}, 3'h7)
      p.span_wide = 1'b0;
      u_amc_host_model.drive(p);
      `CHK(power_state, AMC_PWR_SHUTDOWN)
      `CHK(cfg[5:1], 5'h00)
      p.span_wide = 1'b1;
      p.pd_n = 1'b1;
      u_amc_host_model.drive(p);
      `CHK(power_state, AMC_PWR_NORMAL)
      `CHK(settling, 1'b1)
      repeat (20) @(posedge hclk);
      `CHK(settling, 1'b1)
      repeat (12) @(posedge hclk);
      `CHK(settling, 1'b0)
   endtask
   task automatic t_readout();
      amc_pins_t p;
      for (int i = 0; i < 4; i++) begin
         p = pins;
         p.readout_sel = i[1];
         p.byte_sel = i[0];
         u_amc_host_model.drive(p);
         `CHK(readout_mode, !i[1] ? AMC_RD_PARALLEL : i[0] ? AMC_RD_BYTE : AMC_RD_SERIAL)
      end
   endtask
   task automatic t_conv();
      logic signed [19:0] rv [6] = '{20'sh00000, 20'sh10000, 20'shF0000, 20'sh07FFF,
                                    20'shF8000, 20'shFFFFF};
      logic [15:0]        ev [6] = '{16'h0000, 16'h7FFF, 16'h8000, 16'h7FFF, 16'h8000, 16'hFFFF};
      amc_pins_t          p;
      int                 k;
      int                 n;
      for (int s = 0; s < 2; s++) begin
         p = pins;
         p.span_wide = s[0];
         u_amc_host_model.drive(p);
         for (int i = 0; i < 6; i++) begin
            raw <= rv[i];
            k = n_res;
            u_amc_host_model.convert();
            repeat (2) @(posedge hclk);
            `CHK(n_res, k + 1)
            `CHK(last_code, ev[i])
            ahb(1'b0, `AMC_RESULT_OFS, 32'h0);
            `CHK(rd[15:0], ev[i])
         end
      end
      k = n_res;
      n = 0;
      ahb(1'b1, `AMC_CTRL_OFS, 32'h3);
      while (n_res == k && n < 50) begin
         @(posedge hclk);
         n++;
      end
      `CHK(last_code, ev[5])
      ahb(1'b1, 8'h18, 32'hFFFFFFFF);
      ahb(1'b0, 8'h18, 32'h0);
      `CHK(rd, 32'h0)
   endtask
   task automatic t_regs();
      ahb(1'b0, `AMC_CONV_COUNT_OFS, 32'h0);
      `CHK(rd, 32'hD)
      ahb(1'b0, `AMC_STATUS_OFS, 32'h0);
      `CHK(rd, 32'h203F)
      ahb(1'b1, `AMC_TEST_RAW_OFS, 32'hFFFFFFFF);
      ahb(1'b0, `AMC_TEST_RAW_OFS, 32'h0);
      `CHK(rd, 32'h000FFFFF)
      ahb(1'b0, `AMC_CTRL_OFS, 32'h0);
      `CHK(rd, 32'h1)
      `CHK(hresp, 1'b0)
   endtask
   task automatic summarize();
      if (err_total == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (8) @(posedge hclk);
      `CHK(cfg.bandgap_en, 1'b1)
      t_ref();
      t_span();
      t_power();
      t_readout();
      t_conv();
      t_regs();
      summarize();
   end
   initial begin
      #100000;
      err_total++;
      summarize();
   end
endmodule
`default_nettype wire
